//--- hw/pbs_consts.svh
// constants of the basic status word and its management frame
// assumes the includer uses the names only; no logic lives here
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH

// management address of the status word
`define PBS_STATUS_ADDR 5'h01
// status bit positions
`define PBS_B_T4 15
`define PBS_B_TX_FD 14
`define PBS_B_TX_HD 13
`define PBS_B_TE_FD 12
`define PBS_B_TE_HD 11
`define PBS_B_T2_FD 10
`define PBS_B_T2_HD 9
`define PBS_B_EXT_STAT 8
`define PBS_B_RSVD 7
`define PBS_B_NO_PRE 6
`define PBS_B_AN_DONE 5
`define PBS_B_RFAULT 4
`define PBS_B_AN_ABLE 3
`define PBS_B_LINK 2
`define PBS_B_JABBER 1
`define PBS_B_EXT_CAP 0
// reset value and the fixed part of the word
`define PBS_RESET_WORD 16'h7949
`define PBS_FIXED_MASK 16'hFFC9
// frame coding
`define PBS_PREAMBLE_BITS 6'h20
`define PBS_OP_READ 2'h2
`define PBS_OP_WRITE 2'h1
`define PBS_LAST_DATA 4'hF
`define PBS_LAST_ADDR 4'h9

`endif

//--- hw/pbs_pkg.sv
// types shared by the status word design
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package pbs_pkg;
	// management frame receiver phases
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_START = 3'h1,
		ST_OP = 3'h2,
		ST_ADDR = 3'h3,
		ST_TA = 3'h4,
		ST_DATA = 3'h5
	} pbs_mgmt_state_type;
endpackage

`default_nettype wire

//--- hw/pbs_flag_if.sv
// carrier between the top and one latched status flag
// assumes one clock shared by both ends
`default_nettype none

interface pbs_flag_if;
	logic hit; // latching condition
	logic clr; // release after a read
	logic value; // current flag value
	modport latch (input hit, input clr, output value);
	modport user (output hit, output clr, input value);
endinterface

`default_nettype wire

//--- hw/pbs_sync.sv
// two-flop synchroniser for pin inputs
// assumes an active-low reset copy already released on clock
`default_nettype none

module pbs_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// raw and synchronised values
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	// first stage, read only by the second
	logic [WIDTH-1:0] meta_reg;

	// two stages; reset to a constant only
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			q <= '0;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // pbs_sync

`default_nettype wire

//--- hw/pbs_latch_bit.sv
// one latched status flag, latch-high or latch-low by parameter
// assumes hit and clr come from logic on the same clock
`default_nettype none

module pbs_latch_bit #(
	parameter bit ACTIVE = 1'b1,
	parameter bit RESET_VAL = 1'b0
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// flag connection
	pbs_flag_if.latch flag
);
	// condition wins over a release in the same cycle, so no event is lost
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			flag.value <= RESET_VAL;
		else if (flag.hit)
			flag.value <= ACTIVE;
		else if (flag.clr)
			flag.value <= ~ACTIVE;
	end
endmodule // pbs_latch_bit

`default_nettype wire

//--- hw/pbs_top.sv
// basic status word of the transceiver behind its serial management pins
// assumes mdc is at most one eighth of clock; line events are on clock
`default_nettype none
`include "pbs_consts.svh"

// Functional notes
// - bit 15 reads 0, no T4
// - bits 14,13 read 1, TX duplex modes
// - bits 12,11 read 1, 10 Mb/s modes
// - bits 10,9 read 0, no T2
// - bit 8 reads 1, extended status
// - bit 7 reserved, reads 0, write 0
// - bit 6 reads 1, no preamble accepted
// - preamble once after reset or errors
// - bit 5 shows negotiation done, live from an_complete
// - bit 4 latches remote fault until read
// - far-end or partner fault sets bit 4
// - bit 3 reads 1, can negotiate
// - bit 2 link, failure clears at once
// - link re-sets only after good and read
// - bit 1 jabber, only at 10 Mb/s
// - jabber latches until read or reset
// - bit 0 reads 1, extended registers
// - latch-high holds 1 until read
// - latch-low holds 0 until read
module pbs_top (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// management pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	input wire logic [4:0] phy_address,
	// line-side status
	input wire logic an_complete,
	input wire logic far_end_fault,
	input wire logic partner_remote_fault,
	input wire logic link_good,
	input wire logic jabber_seen,
	input wire logic speed_10
);

	////////////////////////////////////////////////////////////////////////
	// reset release

	logic [1:0] rst_pipe_reg; // release pipeline
	logic rst_n_q; // reset used by the rest

	// assert at once, release after two edges
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			rst_pipe_reg <= 2'h0;
		else
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
	end
	assign rst_n_q = rst_pipe_reg[1];

	////////////////////////////////////////////////////////////////////////
	// pin inputs

	logic mdc_s; // synchronised mdc
	logic mdio_s; // synchronised mdio
	logic [4:0] phy_addr_s; // synchronised address pins
	logic mdc_prev_reg; // mdc one cycle back
	logic rise; // mdc rising edge

	pbs_sync #(
		.WIDTH(7)
	) u_pin_sync (
		.clock(clock),
		.rst_n(rst_n_q),
		.d({mdc, mdio_in, phy_address}),
		.q({mdc_s, mdio_s, phy_addr_s})
	);

	// edge detection works on the second stage only
	always_ff @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
			mdc_prev_reg <= 1'b0;
		else
			mdc_prev_reg <= mdc_s;
	end
	assign rise = mdc_s & ~mdc_prev_reg;

	////////////////////////////////////////////////////////////////////////
	// latched flags

	pbs_flag_if f_rf ();
	pbs_flag_if f_link ();
	pbs_flag_if f_jab ();
	logic read_clear; // pulse when the word is taken for a read

	assign f_rf.hit = far_end_fault | partner_remote_fault;
	assign f_rf.clr = read_clear;
	assign f_link.hit = ~link_good;
	assign f_link.clr = read_clear;
	assign f_jab.hit = jabber_seen & speed_10;
	assign f_jab.clr = read_clear;

	// remote fault, latch high
	pbs_latch_bit #(.ACTIVE(1'b1), .RESET_VAL(1'b0)) u_rf (.clock(clock), .rst_n(rst_n_q), .flag(f_rf));

	// link status, latch low; starts low until a read finds a good link
	pbs_latch_bit #(.ACTIVE(1'b0), .RESET_VAL(1'b0)) u_link (.clock(clock), .rst_n(rst_n_q), .flag(f_link));

	// jabber, latch high
	pbs_latch_bit #(.ACTIVE(1'b1), .RESET_VAL(1'b0)) u_jab (.clock(clock), .rst_n(rst_n_q), .flag(f_jab));

	////////////////////////////////////////////////////////////////////////
	// status word

	logic [15:0] status_word; // live view of the register

	// fixed capabilities plus live and latched bits
	always_comb
	begin
		status_word = `PBS_RESET_WORD;
		status_word[`PBS_B_T4] = 1'b0;
		status_word[`PBS_B_TX_FD] = 1'b1;
		status_word[`PBS_B_TX_HD] = 1'b1;
		status_word[`PBS_B_TE_FD] = 1'b1;
		status_word[`PBS_B_TE_HD] = 1'b1;
		status_word[`PBS_B_T2_FD] = 1'b0;
		status_word[`PBS_B_T2_HD] = 1'b0;
		status_word[`PBS_B_EXT_STAT] = 1'b1;
		status_word[`PBS_B_RSVD] = 1'b0;
		status_word[`PBS_B_NO_PRE] = 1'b1;
		status_word[`PBS_B_AN_DONE] = an_complete;
		status_word[`PBS_B_RFAULT] = f_rf.value;
		status_word[`PBS_B_AN_ABLE] = 1'b1;
		status_word[`PBS_B_LINK] = f_link.value;
		status_word[`PBS_B_JABBER] = f_jab.value;
		status_word[`PBS_B_EXT_CAP] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// frame receiver

	pbs_pkg::pbs_mgmt_state_type state_reg; // frame phase
	logic [3:0] cnt_reg; // bit within phase
	logic [1:0] op_reg; // opcode bits
	logic [8:0] addr_sh_reg; // address bits so far
	logic phy_hit_reg; // frame is for this port
	logic reg_hit_reg; // frame names the status word
	logic pre_ok_reg; // preamble has been seen
	logic [9:0] addr_full; // address with the last bit
	logic [1:0] op_full; // opcode with the last bit
	logic is_read; // opcode is read
	logic rd_active; // this port answers the read
	logic bad_op; // invalid opcode seen
	logic bad_ta; // invalid write turnaround seen
	logic drive_start; // end of first turnaround bit
	logic drive_bit; // next data bit goes out
	logic drive_end; // last data bit done

	assign addr_full = {addr_sh_reg, mdio_s};
	assign op_full = {op_reg[0], mdio_s};
	assign is_read = (op_reg == `PBS_OP_READ);
	assign rd_active = is_read & phy_hit_reg;
	assign bad_op = rise && state_reg == pbs_pkg::ST_OP && cnt_reg == 4'h1
		&& op_full != `PBS_OP_READ && op_full != `PBS_OP_WRITE;
	// a write must carry 1 then 0 in its turnaround
	assign bad_ta = rise && state_reg == pbs_pkg::ST_TA && !is_read
		&& ((cnt_reg == 4'h0 && !mdio_s) || (cnt_reg == 4'h1 && mdio_s));
	assign drive_start = rise && state_reg == pbs_pkg::ST_TA && cnt_reg == 4'h0 && rd_active;
	assign drive_bit = rise && rd_active && ((state_reg == pbs_pkg::ST_TA && cnt_reg == 4'h1)
		|| (state_reg == pbs_pkg::ST_DATA && cnt_reg != `PBS_LAST_DATA));
	assign drive_end = rise && rd_active && state_reg == pbs_pkg::ST_DATA
		&& cnt_reg == `PBS_LAST_DATA;
	// the snapshot and the release share one edge
	assign read_clear = drive_start & reg_hit_reg;

	// phase sequencing, one step per mdc rising edge
	always_ff @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			state_reg <= pbs_pkg::ST_IDLE;
			cnt_reg <= 4'h0;
			op_reg <= 2'h0;
			addr_sh_reg <= 9'h000;
			phy_hit_reg <= 1'b0;
			reg_hit_reg <= 1'b0;
		end
		else if (rise)
		begin
			unique case (state_reg)
				pbs_pkg::ST_IDLE:
				begin
					// a zero after idle ones opens a frame
					if (pre_ok_reg && !mdio_s)
						state_reg <= pbs_pkg::ST_START;
				end
				pbs_pkg::ST_START:
				begin
					cnt_reg <= 4'h0;
					state_reg <= mdio_s ? pbs_pkg::ST_OP : pbs_pkg::ST_IDLE;
				end
				pbs_pkg::ST_OP:
				begin
					op_reg <= op_full;
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == 4'h1)
					begin
						cnt_reg <= 4'h0;
						state_reg <= bad_op ? pbs_pkg::ST_IDLE : pbs_pkg::ST_ADDR;
					end
				end
				pbs_pkg::ST_ADDR:
				begin
					addr_sh_reg <= addr_full[8:0];
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == `PBS_LAST_ADDR)
					begin
						cnt_reg <= 4'h0;
						phy_hit_reg <= (addr_full[9:5] == phy_addr_s);
						reg_hit_reg <= (addr_full[4:0] == `PBS_STATUS_ADDR);
						state_reg <= pbs_pkg::ST_TA;
					end
				end
				pbs_pkg::ST_TA:
				begin
					cnt_reg <= cnt_reg + 4'h1;
					if (bad_ta)
						state_reg <= pbs_pkg::ST_IDLE;
					else if (cnt_reg == 4'h1)
					begin
						cnt_reg <= 4'h0;
						state_reg <= pbs_pkg::ST_DATA;
					end
				end
				pbs_pkg::ST_DATA:
				begin
					// write data is counted through and dropped
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == `PBS_LAST_DATA)
						state_reg <= pbs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// preamble tracking

	logic [5:0] ones_reg; // consecutive idle ones

	// one full preamble arms the receiver; a bad opcode or turnaround disarms it
	always_ff @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ones_reg <= 6'h00;
			pre_ok_reg <= 1'b0;
		end
		else if (bad_op || bad_ta)
		begin
			ones_reg <= 6'h00;
			pre_ok_reg <= 1'b0;
		end
		else if (rise && state_reg == pbs_pkg::ST_IDLE)
		begin
			if (!mdio_s)
				ones_reg <= 6'h00;
			else if (ones_reg != `PBS_PREAMBLE_BITS)
				ones_reg <= ones_reg + 6'h01;
			// arming takes effect from the next bit
			if (mdio_s && ones_reg == `PBS_PREAMBLE_BITS - 6'h01)
				pre_ok_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data drive

	logic [15:0] tx_reg; // word being shifted out

	// drive 0 in the second turnaround bit, then sixteen data bits
	always_ff @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			tx_reg <= 16'h0000;
			mdio_out <= 1'b0;
			mdio_oe_n <= 1'b1;
		end
		else if (drive_start)
		begin
			// other addresses of this port read as zero
			tx_reg <= reg_hit_reg ? status_word : 16'h0000;
			mdio_out <= 1'b0;
			mdio_oe_n <= 1'b0;
		end
		else if (drive_bit)
		begin
			mdio_out <= tx_reg[15];
			tx_reg <= {tx_reg[14:0], 1'b0};
		end
		else if (drive_end)
		begin
			mdio_out <= 1'b0;
			mdio_oe_n <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n_q);

	a_fixed_caps: assert property (
		drive_start && reg_hit_reg |=> (tx_reg & `PBS_FIXED_MASK) == `PBS_RESET_WORD)
		else $error("fixed capability bits wrong in read word");
	a_reserved_zero: assert property (
		drive_start |=> !tx_reg[`PBS_B_RSVD])
		else $error("reserved bit read as one");
	a_an_live: assert property (
		drive_start && reg_hit_reg |=> tx_reg[`PBS_B_AN_DONE] == $past(an_complete))
		else $error("negotiation bit does not follow its input");
	a_rf_cause: assert property (
		$rose(f_rf.value) |-> $past(far_end_fault || partner_remote_fault))
		else $error("remote fault set without cause");
	a_rf_hold: assert property (
		f_rf.value && !read_clear |=> f_rf.value)
		else $error("remote fault dropped without a read");
	a_link_drop: assert property (
		!link_good |=> !f_link.value)
		else $error("link flag not cleared on failure");
	a_link_set: assert property (
		$rose(f_link.value) |-> $past(read_clear) && $past(link_good))
		else $error("link flag set without a read");
	a_jab_cause: assert property (
		$rose(f_jab.value) |-> $past(jabber_seen && speed_10))
		else $error("jabber set outside 10 Mb/s");
	a_jab_hold: assert property (
		f_jab.value && !read_clear |=> f_jab.value)
		else $error("jabber dropped without a read");
	a_read_snap: assert property (
		read_clear && f_rf.value |=> tx_reg[`PBS_B_RFAULT] && !mdio_oe_n && !mdio_out)
		else $error("read lost the latched fault");
	a_pre_gate: assert property (
		rise && state_reg == pbs_pkg::ST_IDLE && !pre_ok_reg |=> state_reg == pbs_pkg::ST_IDLE)
		else $error("frame opened before a preamble");
	a_write_inert: assert property (
		state_reg == pbs_pkg::ST_DATA && !is_read |-> mdio_oe_n && !read_clear)
		else $error("write frame disturbed the port");

	c_status_read: cover property (read_clear);
	c_rf_read: cover property (read_clear && f_rf.value);
	c_bad_op: cover property (bad_op);
	c_link_back: cover property ($rose(f_link.value));
	c_bad_ta: cover property (bad_ta);

endmodule // pbs_top

`default_nettype wire

//--- testbench/pbs_mgmt_model.sv
// management controller model driving the serial management pins
// assumes the device samples on rising mdc and the data line has a pull-up
`default_nettype none
`include "pbs_consts.svh"

module pbs_mgmt_model (
	// system clock
	input wire logic clock,
	// management pins
	output logic mdc,
	output logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////
	logic drv = 1'b0; // controller drives the line
	logic val = 1'b1; // bit the controller drives
	logic smp = 1'b1; // line level at the last rising mdc

	// wire level: device first, then controller, else the pull-up
	assign mdio_in = !mdio_oe_n ? mdio_out : (drv ? val : 1'b1);
	// clock stands low outside frames
	initial mdc = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// one mdc period of 16 clocks; line sampled just before the rise
	task automatic send_bit(input logic b, input logic d);
		drv = d;
		val = b;
		repeat (8) @(posedge clock);
		#2;
		smp = mdio_in;
		mdc = 1'b1;
		repeat (8) @(posedge clock);
		#2;
		mdc = 1'b0;
	endtask

	// one frame; a read releases the line after the address
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, input bit pre, output logic [15:0] rd, output logic ta_ok);
		logic [13:0] hdr;
		logic rd_op;
		hdr = {2'b01, op, pa, ra};
		rd_op = (op == `PBS_OP_READ);
		wd[`PBS_B_RSVD] = 1'b0;
		ta_ok = 1'b1;
		rd = 16'h0000;
		if (pre)
			repeat (32) send_bit(1'b1, 1'b1);
		for (int i = 13; i >= 0; i--)
			send_bit(hdr[i], 1'b1);
		for (int i = 17; i >= 0; i--)
		begin
			// write: turnaround 10 then data
			send_bit((i == 17) ? 1'b1 : (i == 16) ? 1'b0 : wd[i], !rd_op);
			// read: first turnaround bit floats high, second is driven low
			if (i == 17 && smp !== 1'b1)
				ta_ok = 1'b0;
			if (i == 16 && smp !== 1'b0)
				ta_ok = 1'b0;
			if (i < 16)
				rd[i] = smp;
		end
		drv = 1'b0;
	endtask
endmodule // pbs_mgmt_model

`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the basic status word behind the management pins
// assumes the controller model of pbs_mgmt_model; line events on clock
`default_nettype none
`include "pbs_consts.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [4:0] phy_address = 5'h05;
	logic an_complete = 1'b0;
	logic far_end_fault = 1'b0;
	logic partner_remote_fault = 1'b0;
	logic link_good = 1'b0;
	logic jabber_seen = 1'b0;
	logic speed_10 = 1'b0;
	wire logic mdc;
	wire logic mdio_in;
	wire logic mdio_out;
	wire logic mdio_oe_n;
	int fail_count = 0;
	int num_checks = 0;
	logic [15:0] word;
	logic ta_ok;

	// 20 MHz clock
	always #25 clock = ~clock;

	pbs_top DUT (.clock(clock), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_address(phy_address),
		.an_complete(an_complete), .far_end_fault(far_end_fault),
		.partner_remote_fault(partner_remote_fault), .link_good(link_good),
		.jabber_seen(jabber_seen), .speed_10(speed_10));
	pbs_mgmt_model MGR (.clock(clock), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// expected word: fixed part plus live and latched flags
	function automatic logic [15:0] ew(input logic an, input logic rf, input logic lk, input logic jb);
		ew = `PBS_RESET_WORD | {10'h000, an, rf, 1'b0, lk, jb, 1'b0};
	endfunction

	// inputs move 2 ns after the edge so sampling never races
	task automatic tick();
		@(posedge clock);
		#2;
	endtask

	// read the word, then check turnaround and line release
	task automatic rd(input string name, input bit pre, input logic [15:0] exp);
		MGR.frame(`PBS_OP_READ, phy_address, `PBS_STATUS_ADDR, 16'h0000, pre, word, ta_ok);
		chk(name, exp, word);
		chk({name, " ta"}, 16'h0001, {15'h0000, ta_ok});
		chk({name, " release"}, 16'h0001, {15'h0000, mdio_oe_n});
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_fixed();
		rd("reset word", 1, ew(0, 0, 0, 0));
		rd("no preamble", 0, ew(0, 0, 0, 0));
		an_complete = 1'b1;
		rd("negotiated", 0, ew(1, 0, 0, 0));
		an_complete = 1'b0;
		rd("negotiating", 0, ew(0, 0, 0, 0));
		$display("test fixed done");
	endtask

	task automatic t_fault();
		far_end_fault = 1'b1;
		tick();
		far_end_fault = 1'b0;
		rd("far fault", 0, ew(0, 1, 0, 0));
		rd("fault cleared", 0, ew(0, 0, 0, 0));
		partner_remote_fault = 1'b1;
		tick();
		partner_remote_fault = 1'b0;
		// reading another register or another port must not release the latch
		MGR.frame(`PBS_OP_READ, phy_address, 5'h02, 16'h0000, 0, word, ta_ok);
		chk("other reg", 16'h0000, word);
		MGR.frame(`PBS_OP_READ, phy_address + 5'h01, `PBS_STATUS_ADDR, 16'h0000, 0, word, ta_ok);
		chk("other port", 16'hFFFF, word);
		rd("partner fault", 0, ew(0, 1, 0, 0));
		$display("test fault done");
	endtask

	task automatic t_link();
		link_good = 1'b1;
		rd("link pre-read", 0, ew(0, 0, 0, 0));
		rd("link up", 0, ew(0, 0, 1, 0));
		link_good = 1'b0;
		tick();
		link_good = 1'b1;
		rd("link drop", 0, ew(0, 0, 0, 0));
		rd("link back", 0, ew(0, 0, 1, 0));
		$display("test link done");
	endtask

	task automatic t_jabber();
		jabber_seen = 1'b1;
		tick();
		jabber_seen = 1'b0;
		rd("jabber fast", 0, ew(0, 0, 1, 0));
		speed_10 = 1'b1;
		jabber_seen = 1'b1;
		tick();
		jabber_seen = 1'b0;
		rd("jabber slow", 0, ew(0, 0, 1, 1));
		rd("jabber cleared", 0, ew(0, 0, 1, 0));
		$display("test jabber done");
	endtask

	task automatic t_write();
		MGR.frame(`PBS_OP_WRITE, phy_address, `PBS_STATUS_ADDR, 16'hFFFF, 0, word, ta_ok);
		rd("after write", 0, ew(0, 0, 1, 0));
		// bad opcode drops arming; nothing answers until a new preamble
		MGR.frame(2'h0, phy_address, `PBS_STATUS_ADDR, 16'h0000, 0, word, ta_ok);
		MGR.frame(`PBS_OP_READ, phy_address, `PBS_STATUS_ADDR, 16'h0000, 0, word, ta_ok);
		chk("unarmed read", 16'hFFFF, word);
		chk("unarmed ta", 16'h0000, {15'h0000, ta_ok});
		rd("rearmed", 1, ew(0, 0, 1, 0));
		// a write whose turnaround is 11 disarms the receiver as well
		word = {2'b01, `PBS_OP_WRITE, phy_address, `PBS_STATUS_ADDR, 2'b11};
		for (int i = 15; i >= 0; i--)
			MGR.send_bit(word[i], 1'b1);
		MGR.frame(`PBS_OP_READ, phy_address, `PBS_STATUS_ADDR, 16'h0000, 0, word, ta_ok);
		chk("bad ta read", 16'hFFFF, word);
		rd("rearmed after ta", 1, ew(0, 0, 1, 0));
		$display("test write done");
	endtask

	task automatic t_reset();
		jabber_seen = 1'b1;
		tick();
		jabber_seen = 1'b0;
		reset_n = 1'b0;
		repeat (3) tick();
		reset_n = 1'b1;
		repeat (8) tick();
		rd("second reset", 1, ew(0, 0, 0, 0));
		$display("test reset done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// bound on the whole run
	initial
	begin
		repeat (100000) @(posedge clock);
		fail_count++;
		$display("MISMATCH run length expected end seen timeout");
		complete_run();
	end

	initial
	begin
		repeat (3) tick();
		reset_n = 1'b1;
		repeat (8) tick();
		t_fixed();
		t_fault();
		t_link();
		t_jabber();
		t_write();
		t_reset();
		complete_run();
	end
endmodule // tb

`default_nettype wire
